// ===== pcc_capture.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
// =====================================================================
// parallel camera capture, sampled on the system clock
// =====================================================================
module pcc_capture #(
  parameter int DEPTH = 8,                   // buffer words
  parameter logic [7:0] REV_MAJOR = 8'h01,   // arbitrary value
  parameter logic [7:0] REV_MINOR = 8'h00    // arbitrary value
) (
  input wire logic sys_clk_i,                // system clock
  input wire logic rstn_i,                   // synchronous reset, active low
  input wire logic pclk_i,                   // pixel clock from sensor
  input wire logic vsync_i,                  // frame sync
  input wire logic hsync_i,                  // line sync
  input wire logic [11:0] pixel_data_in_i,   // pixel data
  input wire logic [7:0] addr_i,             // register byte address
  input wire logic [31:0] wdata_i,           // write data
  input wire logic wr_i,                     // write strobe
  input wire logic rd_i,                     // read strobe
  output logic [31:0] rdata_o,               // read data, cycle after rd_i
  output logic irq_o,                        // interrupt, level
  output logic dma_req_o                     // dma read request, level
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = 4;

  // buffer must fit the 4-bit threshold fields, refused at elaboration
  if (DEPTH < 2 || DEPTH > 8 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be 2, 4 or 8");
  end

  typedef enum logic [0:0] {ST_IDLE, ST_ACT} pcc_state_t;

  // masks a raw sample to the configured pixel width
  function automatic logic [11:0] pix_val(input logic [11:0] d, input logic [1:0] w);
    logic [11:0] r;
    r = d;
    case (w)
      pcc_pkg::WID_8: r = {4'h0, d[7:0]};
      pcc_pkg::WID_10: r = {2'h0, d[9:0]};
      default: r = d;
    endcase
    return r;
  endfunction

  // =====================================================================
  // pin synchronisation and pixel clock edge
  // =====================================================================
  pcc_pkg::pcc_pins_t pins_raw;
  pcc_pkg::pcc_pins_t pins_s;
  assign pins_raw = '{pclk: pclk_i, vsync: vsync_i, hsync: hsync_i, data: pixel_data_in_i};

  // data and clock share one delay, so each rise still finds stable data
  pcc_sync #(.W($bits(pcc_pkg::pcc_pins_t))) u_sync (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .d_i(pins_raw),
    .q_o(pins_s)
  );

  logic pclk_prev_q;
  logic vs_prev_q;
  pcc_pkg::pcc_ctrl_t ctrl_q;
  logic [11:0] sav_q;
  logic [11:0] eav_q;
  logic [3:0] ien_q;
  logic done_q;
  pcc_state_t st_q;
  logic [31:0] asm_q;
  logic [1:0] asm_n_q;
  logic [31:0] mem [DEPTH];
  logic [PW-1:0] wptr_q;
  logic [PW-1:0] rptr_q;
  logic [CW-1:0] cnt_q;

  // =====================================================================
  // framing decode
  // =====================================================================
  wire pix_stb = pins_s.pclk && !pclk_prev_q;
  wire vs_rise = pins_s.vsync && !vs_prev_q;
  wire [11:0] pix = pix_val(pins_s.data, ctrl_q.width);
  wire sav_hit = pix == pix_val(sav_q, ctrl_q.width);
  wire eav_hit = pix == pix_val(eav_q, ctrl_q.width);
  wire sync_start = vs_rise && pins_s.hsync;
  wire start_ok = ctrl_q.ets ? sav_hit : sync_start;
  wire armed = ctrl_q.en && ctrl_q.mode != pcc_pkg::MODE_OFF;
  wire frame_start = pix_stb && armed && st_q == ST_IDLE && start_ok;
  wire frame_end = pix_stb && st_q == ST_ACT && (ctrl_q.ets ? eav_hit : vs_rise);
  // in continuous sync mode the closing edge may open the next frame at once
  wire restart = ctrl_q.mode == pcc_pkg::MODE_CONT && !ctrl_q.ets && sync_start;
  wire take = pix_stb && st_q == ST_ACT && !frame_end && (ctrl_q.ets || pins_s.hsync);

  // =====================================================================
  // word assembly
  // =====================================================================
  wire wide = ctrl_q.width != pcc_pkg::WID_8;
  wire [31:0] asm_d = wide ? {4'h0, pix, asm_q[31:16]} : {pix[7:0], asm_q[31:8]};
  wire asm_last = wide ? asm_n_q == 2'h1 : asm_n_q == 2'h3;
  wire push = take && asm_last;

  // =====================================================================
  // buffer control
  // =====================================================================
  wire rd_data = rd_i && addr_i == pcc_pkg::OFF_DATA;
  wire pop = rd_data && cnt_q != '0;
  wire full = cnt_q == CW'(DEPTH);
  wire wr_ok = push && !full;
  wire flag_thr = cnt_q >= ctrl_q.fifo_thr;
  wire flag_ne = cnt_q != '0;
  wire [3:0] flags = {flag_ne, full, flag_thr, done_q};
  wire dma_d = ctrl_q.dma_en && ctrl_q.dma_thr != 4'h0 && cnt_q >= ctrl_q.dma_thr;
  wire single_done = frame_end && ctrl_q.mode == pcc_pkg::MODE_SINGLE;

  // =====================================================================
  // register decode
  // =====================================================================
  wire wr_ctrl = wr_i && addr_i == pcc_pkg::OFF_CTRL;
  wire wr_ien = wr_i && addr_i == pcc_pkg::OFF_IEN;
  wire wr_codes = wr_i && addr_i == pcc_pkg::OFF_CODES;
  wire clr_done = wr_i && addr_i == pcc_pkg::OFF_FLAGS && wdata_i[pcc_pkg::FL_DONE];
  wire [31:0] ctrl_rd = {ctrl_q.en, 10'h0, ctrl_q.dma_thr, ctrl_q.dma_en, 7'h0,
                         ctrl_q.fifo_thr, ctrl_q.ets, ctrl_q.mode, ctrl_q.width};
  wire [31:0] rd_mux =
      addr_i == pcc_pkg::OFF_REV   ? {16'h0, REV_MAJOR, REV_MINOR} :
      addr_i == pcc_pkg::OFF_FSIZE ? 32'(DEPTH) :
      addr_i == pcc_pkg::OFF_CTRL  ? ctrl_rd :
      addr_i == pcc_pkg::OFF_IEN   ? {28'h0, ien_q} :
      addr_i == pcc_pkg::OFF_FLAGS ? {28'h0, flags} :
      addr_i == pcc_pkg::OFF_CODES ? {4'h0, eav_q, 4'h0, sav_q} :
      addr_i == pcc_pkg::OFF_DATA  ? (flag_ne ? mem[rptr_q] : 32'h0) :
      32'h0;

  // software settings; hardware drops a finished single capture to off
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      ctrl_q <= '{en: 1'b0, dma_en: 1'b0, dma_thr: pcc_pkg::DTHR_RST,
                  fifo_thr: pcc_pkg::FTHR_RST, ets: 1'b0, mode: pcc_pkg::MODE_OFF,
                  width: pcc_pkg::WID_8};
    end else begin
      if (wr_ctrl) begin
        ctrl_q.en <= wdata_i[pcc_pkg::CTRL_EN_BIT];
        ctrl_q.dma_en <= wdata_i[pcc_pkg::CTRL_DMA_BIT];
        ctrl_q.dma_thr <= wdata_i[pcc_pkg::CTRL_DTHR_LSB +: 4];
        ctrl_q.fifo_thr <= wdata_i[pcc_pkg::CTRL_FTHR_LSB +: 4];
        ctrl_q.ets <= wdata_i[pcc_pkg::CTRL_ETS_BIT];
        ctrl_q.mode <= wdata_i[pcc_pkg::CTRL_MODE_LSB +: 2];
        ctrl_q.width <= wdata_i[pcc_pkg::CTRL_WIDTH_LSB +: 2];
      end
      if (single_done) begin
        ctrl_q.mode <= pcc_pkg::MODE_OFF;
      end
    end
  end

  // enables and timing codes
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      ien_q <= 4'h0;
      sav_q <= 12'h000;
      eav_q <= 12'h000;
    end else begin
      if (wr_ien) ien_q <= wdata_i[3:0];
      if (wr_codes) sav_q <= wdata_i[pcc_pkg::CODE_SAV_LSB +: 12];
      if (wr_codes) eav_q <= wdata_i[pcc_pkg::CODE_EAV_LSB +: 12];
    end
  end

  // done flag: a frame end in the clearing cycle still sets it
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      done_q <= 1'b0;
    end else if (frame_end) begin
      done_q <= 1'b1;
    end else if (clr_done) begin
      done_q <= 1'b0;
    end
  end

  // =====================================================================
  // capture state
  // =====================================================================
  // vs_prev_q follows the pin only at pixel edges, so a pulse of one
  // pixel period is seen exactly once
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      pclk_prev_q <= 1'b0;
      vs_prev_q <= 1'b0;
    end else begin
      pclk_prev_q <= pins_s.pclk;
      if (pix_stb) vs_prev_q <= pins_s.vsync;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: if (frame_start) st_q <= ST_ACT;
        ST_ACT: begin
          if (!ctrl_q.en || ctrl_q.mode == pcc_pkg::MODE_OFF) st_q <= ST_IDLE;
          else if (frame_end) st_q <= restart ? ST_ACT : ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // partial words are dropped at frame start rather than mixed in
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      asm_q <= 32'h0;
      asm_n_q <= 2'h0;
    end else if (frame_start || frame_end) begin
      asm_n_q <= 2'h0;
    end else if (take) begin
      asm_q <= asm_d;
      asm_n_q <= asm_last ? 2'h0 : asm_n_q + 2'h1;
    end
  end

  // =====================================================================
  // receive buffer
  // =====================================================================
  always_ff @(posedge sys_clk_i) begin
    if (wr_ok) mem[wptr_q] <= asm_d;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (wr_ok) wptr_q <= wptr_q + PW'(1);
      if (pop) rptr_q <= rptr_q + PW'(1);
      cnt_q <= cnt_q + CW'(wr_ok) - CW'(pop);
    end
  end

  // =====================================================================
  // outputs
  // =====================================================================
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      rdata_o <= 32'h0;
      irq_o <= 1'b0;
      dma_req_o <= 1'b0;
    end else begin
      rdata_o <= rd_i ? rd_mux : 32'h0;
      irq_o <= |(flags & ien_q);
      dma_req_o <= dma_d;
    end
  end

  // =====================================================================
  // checks
  // =====================================================================
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_fill_bound;
    cnt_q <= CW'(DEPTH);
  endproperty
  a_fill_bound: assert property (p_fill_bound)
    else $error("buffer count above depth");

  property p_drop_full;
    (full && push && !pop) |=> (full && $stable(wptr_q));
  endproperty
  a_drop_full: assert property (p_drop_full)
    else $error("word stored into full buffer");

  property p_drain_ne;
    (cnt_q == 4'h1 && pop && !wr_ok) |=> !flag_ne ##1
      (rdata_o == 32'h0 || !$past(rd_i) || $past(addr_i) != pcc_pkg::OFF_DATA);
  endproperty
  a_drain_ne: assert property (p_drain_ne)
    else $error("not-empty stayed after last word read");

  property p_done_set;
    frame_end |=> done_q;
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("frame end did not set done");

  property p_done_clr;
    (clr_done && !frame_end && done_q) |=> !done_q;
  endproperty
  a_done_clr: assert property (p_done_clr)
    else $error("write one did not clear done");

  property p_single_off;
    single_done |=> ctrl_q.mode == pcc_pkg::MODE_OFF ##1 st_q == ST_IDLE;
  endproperty
  a_single_off: assert property (p_single_off)
    else $error("single capture did not stop");

  property p_dma_level;
    (ctrl_q.dma_en && ctrl_q.dma_thr != 4'h0 && cnt_q >= ctrl_q.dma_thr) |=> dma_req_o;
  endproperty
  a_dma_level: assert property (p_dma_level)
    else $error("dma request missing at level");

  property p_dma_zero;
    (ctrl_q.dma_thr == 4'h0 || !ctrl_q.dma_en) |=> !dma_req_o;
  endproperty
  a_dma_zero: assert property (p_dma_zero)
    else $error("dma request with zero level or disabled");

  property p_embed_ignores_sync;
    (st_q == ST_IDLE && ctrl_q.ets && pix_stb && !sav_hit) |=> st_q == ST_IDLE;
  endproperty
  a_embed_ignores_sync: assert property (p_embed_ignores_sync)
    else $error("embedded mode started without start code");

  property p_sync_start;
    (st_q == ST_IDLE && !ctrl_q.ets && pix_stb && armed && vs_rise && pins_s.hsync)
      |=> st_q == ST_ACT;
  endproperty
  a_sync_start: assert property (p_sync_start)
    else $error("frame sync rise did not start capture");

  property p_byte_order;
    (push && !wide) |-> asm_d[31:24] == pins_s.data[7:0];
  endproperty
  a_byte_order: assert property (p_byte_order)
    else $error("newest byte not on top");

endmodule // pcc_capture

// ===== pcc_pkg.sv
// =====================================================================
// shared constants and carriers for the camera port
// =====================================================================
package pcc_pkg;

  // =====================================================================
  // register map (byte addresses)
  // =====================================================================
  localparam logic [7:0] OFF_REV   = 8'h00;
  localparam logic [7:0] OFF_FSIZE = 8'h04;
  localparam logic [7:0] OFF_CTRL  = 8'h08;
  localparam logic [7:0] OFF_IEN   = 8'h0C;
  localparam logic [7:0] OFF_FLAGS = 8'h10;
  localparam logic [7:0] OFF_CODES = 8'h14;
  localparam logic [7:0] OFF_DATA  = 8'h30;

  // =====================================================================
  // capture_control field positions
  // =====================================================================
  localparam int CTRL_WIDTH_LSB = 0;   // [1:0] pixel width
  localparam int CTRL_MODE_LSB = 2;    // [3:2] capture mode
  localparam int CTRL_ETS_BIT = 4;     // embedded_timing_select
  localparam int CTRL_FTHR_LSB = 5;    // [8:5] fifo level threshold
  localparam int CTRL_DMA_BIT = 16;    // receive dma enable
  localparam int CTRL_DTHR_LSB = 17;   // [20:17] dma level
  localparam int CTRL_EN_BIT = 31;     // interface enable

  // irq_enable / irq_flags bit positions
  localparam int FL_DONE = 0;
  localparam int FL_THR = 1;
  localparam int FL_FULL = 2;
  localparam int FL_NE = 3;

  // embedded_sync_codes field positions
  localparam int CODE_SAV_LSB = 0;     // [11:0]
  localparam int CODE_EAV_LSB = 16;    // [27:16]

  // =====================================================================
  // reset values and encodings
  // =====================================================================
  localparam logic [3:0] DTHR_RST = 4'h1;
  localparam logic [3:0] FTHR_RST = 4'h1;
  localparam logic [1:0] WID_8 = 2'h0;
  localparam logic [1:0] WID_10 = 2'h1;
  localparam logic [1:0] WID_12 = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;

  // pins as seen from the sensor
  typedef struct packed {
    logic pclk;
    logic vsync;
    logic hsync;
    logic [11:0] data;
  } pcc_pins_t;

  // software settings that steer capture
  typedef struct packed {
    logic en;
    logic dma_en;
    logic [3:0] dma_thr;
    logic [3:0] fifo_thr;
    logic ets;
    logic [1:0] mode;
    logic [1:0] width;
  } pcc_ctrl_t;

endpackage

// ===== pcc_sync.sv
`timescale 1ns/1ps
// =====================================================================
// two-stage synchroniser for pins from outside the system clock
// =====================================================================
module pcc_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk_i,        // system clock
  input wire logic rstn_i,           // synchronous reset, active low
  input wire logic [W-1:0] d_i,      // asynchronous input
  output logic [W-1:0] q_o           // synchronised output
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule // pcc_sync

// ===== pcc_sensor.sv
`timescale 1ns/1ps
// =====================================================================
// behavioural image sensor on the parallel pixel pins
// =====================================================================
module pcc_sensor (
  output logic pclk_o,         // pixel clock, low outside frames
  output logic vsync_o,        // frame sync
  output logic hsync_o,        // line sync
  output logic [11:0] data_o   // pixel data
);
  initial begin
    pclk_o = 1'b0;
    vsync_o = 1'b0;
    hsync_o = 1'b0;
    data_o = 12'h5A5;
  end

  // one pixel period of 80 ns: outputs move while the clock is low
  task automatic pix(input logic vs, input logic hs, input logic [11:0] d);
    begin
      vsync_o = vs;
      hsync_o = hs;
      data_o = d;
      #40 pclk_o = 1'b1;
      #40 pclk_o = 1'b0;
    end
  endtask

  // between frames data is not held, so a stale value can never match
  task automatic idle();
    begin
      vsync_o = 1'b0;
      hsync_o = 1'b0;
      data_o = ~data_o;
    end
  endtask
endmodule // pcc_sensor

// ===== tb.sv
`timescale 1ns/1ps
// =====================================================================
// self-checking bench for the camera port
// =====================================================================
module tb;
  localparam logic [7:0] MAJ = 8'h3C;  // arbitrary value
  localparam logic [7:0] MIN = 8'h07;  // arbitrary value
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic irq_o;
  logic dma_req_o;
  logic pclk;
  logic vsync;
  logic hsync;
  logic [11:0] pdata;
  logic [31:0] v;
  logic [11:0] m;
  int fail_count = 0;
  int n_checks = 0;

  // system clock, 8 ns
  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  pcc_sensor s (.pclk_o(pclk), .vsync_o(vsync), .hsync_o(hsync), .data_o(pdata));

  pcc_capture #(.DEPTH(8), .REV_MAJOR(MAJ), .REV_MINOR(MIN)) dut (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .pclk_i(pclk), .vsync_i(vsync),
    .hsync_i(hsync), .pixel_data_in_i(pdata), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .dma_req_o(dma_req_o));

  // =====================================================================
  // reporting and bus tasks
  // =====================================================================
  task automatic close_out();
    begin
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
      n_checks++;
      if (got !== exp) begin
        fail_count++;
        $display("Error %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge sys_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
    end
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    begin
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
    end
  endtask

  task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    begin
      rd(a, d);
      chk(what, exp, d);
    end
  endtask

  // =====================================================================
  // expected values
  // =====================================================================
  function automatic logic [7:0] bt(input int i);
    return 8'(i * 29 + 3);
  endfunction

  function automatic logic [31:0] wd(input int k);
    return {bt(4 * k + 3), bt(4 * k + 2), bt(4 * k + 1), bt(4 * k)};
  endfunction

  function automatic logic [31:0] mk(input logic [1:0] w, input logic [1:0] md,
      input logic e, input logic [3:0] ft, input logic de, input logic [3:0] dt);
    return (32'h1 << pcc_pkg::CTRL_EN_BIT) | (32'(dt) << pcc_pkg::CTRL_DTHR_LSB)
      | (32'(de) << pcc_pkg::CTRL_DMA_BIT) | (32'(ft) << pcc_pkg::CTRL_FTHR_LSB)
      | (32'(e) << pcc_pkg::CTRL_ETS_BIT) | (32'(md) << pcc_pkg::CTRL_MODE_LSB) | 32'(w);
  endfunction

  // sync-pin frame of n bytes; junk in the upper nibble, one gap without line sync
  task automatic frame8(input int n);
    begin
      #3;
      s.pix(1'b0, 1'b0, 12'h000);
      s.pix(1'b1, 1'b1, 12'hE77);
      for (int i = 0; i < n; i++) begin
        if (i == 2) s.pix(1'b0, 1'b0, 12'h0CC);
        s.pix(1'b0, 1'b1, {4'hB, bt(i)});
      end
      s.pix(1'b1, 1'b0, 12'h0DD);
      s.pix(1'b0, 1'b0, 12'h000);
      s.idle();
      repeat (12) @(posedge sys_clk_i);
    end
  endtask

  // =====================================================================
  // main sequence
  // =====================================================================
  initial begin
    repeat (8) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    rc("rev", pcc_pkg::OFF_REV, {16'h0, MAJ, MIN});
    wr(pcc_pkg::OFF_REV, 32'hFFFFFFFF);
    rc("rev ro", pcc_pkg::OFF_REV, {16'h0, MAJ, MIN});
    rc("fsize", pcc_pkg::OFF_FSIZE, 32'h8);
    rc("ctrl rst", pcc_pkg::OFF_CTRL, (32'(pcc_pkg::DTHR_RST) << pcc_pkg::CTRL_DTHR_LSB)
       | (32'(pcc_pkg::FTHR_RST) << pcc_pkg::CTRL_FTHR_LSB));
    rc("ien rst", pcc_pkg::OFF_IEN, 32'h0);
    rc("flags rst", pcc_pkg::OFF_FLAGS, 32'h0);
    rc("codes rst", pcc_pkg::OFF_CODES, 32'h0);
    rc("unmapped", 8'h20, 32'h0);
    rc("empty pop", pcc_pkg::OFF_DATA, 32'h0);
    chk1("dma rst", 1'b0, dma_req_o);
    // 8-bit, sync pins, single image
    wr(pcc_pkg::OFF_IEN, 32'h1);
    wr(pcc_pkg::OFF_CTRL,
       mk(pcc_pkg::WID_8, pcc_pkg::MODE_SINGLE, 1'b0, 4'h1, 1'b0, 4'h1));
    frame8(4);
    rc("flags img", pcc_pkg::OFF_FLAGS, 32'hB);
    chk1("irq done", 1'b1, irq_o);
    rc("ctrl single", pcc_pkg::OFF_CTRL, mk(2'h0, 2'h0, 1'b0, 4'h1, 1'b0, 4'h1));
    rc("word8", pcc_pkg::OFF_DATA, wd(0));
    rc("flags drained", pcc_pkg::OFF_FLAGS, 32'h1);
    wr(pcc_pkg::OFF_FLAGS, 32'h1);
    rc("flags w1c", pcc_pkg::OFF_FLAGS, 32'h0);
    chk1("irq clr", 1'b0, irq_o);
    frame8(4);
    rc("mode off", pcc_pkg::OFF_FLAGS, 32'h0);
    // embedded codes, 10-bit single and 12-bit continuous
    wr(pcc_pkg::OFF_CODES, 32'h00F000FF);
    for (int w = 1; w <= 2; w++) begin
      m = (w == 1) ? 12'h3FF : 12'hFFF;
      wr(pcc_pkg::OFF_CTRL, mk(2'(w), 2'(w), 1'b1, 4'h1, 1'b0, 4'h1));
      #3;
      s.pix(1'b0, 1'b1, 12'h123);
      s.pix(1'b1, 1'b1, 12'h0FF);
      s.pix(1'b0, 1'b0, 12'hC12);
      s.pix(1'b1, 1'b1, 12'h345);
      s.pix(1'b1, 1'b0, 12'h0F0);
      s.idle();
      repeat (12) @(posedge sys_clk_i);
      rc("word wide", pcc_pkg::OFF_DATA, {4'h0, 12'h345 & m, 4'h0, 12'hC12 & m});
      rc("flags eav", pcc_pkg::OFF_FLAGS, 32'h1);
      rc("ctrl mode", pcc_pkg::OFF_CTRL, mk(2'(w), 2'(2*w-2), 1'b1, 4'h1, 1'b0, 4'h1));
      wr(pcc_pkg::OFF_FLAGS, 32'h1);
    end
    // 8-bit continuous into a full buffer with dma
    wr(pcc_pkg::OFF_IEN, 32'h4);
    wr(pcc_pkg::OFF_CTRL, mk(pcc_pkg::WID_8, pcc_pkg::MODE_CONT, 1'b0, 4'h3, 1'b1, 4'h2));
    frame8(40);
    rc("flags full", pcc_pkg::OFF_FLAGS, 32'hF);
    chk1("irq full", 1'b1, irq_o);
    chk1("dma req", 1'b1, dma_req_o);
    for (int i = 0; i < 8; i++) begin
      rc("word kept", pcc_pkg::OFF_DATA, wd(i));
      rd(pcc_pkg::OFF_FLAGS, v);
      chk1("level", 7 - i >= 3, v[pcc_pkg::FL_THR]);
      chk1("dma level", 7 - i >= 2, dma_req_o);
    end
    rc("flags end", pcc_pkg::OFF_FLAGS, 32'h1);
    rc("empty", pcc_pkg::OFF_DATA, 32'h0);
    close_out();
  end

  // watchdog against a hang
  initial begin
    repeat (30000) @(posedge sys_clk_i);
    fail_count++;
    close_out();
  end
endmodule // tb
